//--- verification/adcc_core_model.sv
// Behavioural analog converter core facing the control block.
// Assumes core outputs are registered and conv_start is a one-cycle pulse.
`timescale 1ns/10ps
module adcc_core_model
    import adcc_pkg::*;
#(
    parameter int LATENCY = 20
)
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst_b,
    // Control side
    input  adcc_core_s       core,
    input  wire logic [11:0] sample,
    output logic             conv_done,
    output logic      [11:0] conv_result
);
    int cnt;

    // Conversion timer; reset line aborts a running conversion
    always_ff @(posedge clock)
    begin
        conv_done <= 1'b0;
        conv_result <= ~conv_result; // Result only valid with done
        if (!rst_b || core.conv_reset)
            cnt <= 0;
        else if (core.conv_start)
            cnt <= LATENCY;
        else if (cnt > 0)
        begin
            cnt <= cnt - 1;
            if (cnt == 1)
            begin
                conv_done <= 1'b1;
                conv_result <= sample;
            end
        end
    end
endmodule // adcc_core_model

//--- verification/tb_top.sv
// Register-level bench for the converter control block.
// Assumes one-cycle Wishbone acks and a registered core interface.
`timescale 1ns/10ps
module tb_top;
    import adcc_pkg::*;
    logic        clock, rst_b, wb_cyc_i, wb_stb_i, wb_we_i;
    logic [4:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, v;
    logic        wb_ack_o, conv_done;
    logic [11:0] conv_result, sample;
    adcc_core_s  core;
    logic [7:0]  pin_analog_enable_bits, pull_high_block;
    int          n_errors, n_tests, cnt;

    adcc_ctrl u_dut (.clock(clock), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .conv_done(conv_done),
        .conv_result(conv_result), .core(core),
        .pin_analog_enable_bits(pin_analog_enable_bits),
        .pull_high_block(pull_high_block));
    adcc_core_model u_core (.clock(clock), .rst_b(rst_b), .core(core),
        .sample(sample), .conv_done(conv_done),
        .conv_result(conv_result));

    // 40 MHz clock
    initial
    begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got,
                exp);
        end
    endtask

    // Classic single cycle; waits for ack under a bound
    task automatic xfer(input logic we, input logic [4:0] a,
                        input logic [7:0] d);
        @(posedge clock);
        {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, we};
        wb_adr_i <= a;
        wb_dat_i <= {24'h0, d};
        for (int i = 0; i < 50; i++)
        begin
            @(posedge clock);
            if (wb_ack_o === 1'b1)
                break;
            if (i == 49)
                chk(32'hDEAD, 32'h0);
        end
        v = wb_dat_o;
        {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
        repeat (2) @(posedge clock);
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        xfer(1'b1, a, d);
    endtask

    // Start, poll busy, then compare both result bytes
    task automatic conv(input logic [7:0] cfg, input logic [15:0] res);
        wr(5'h08, 8'h80 | cfg);
        xfer(1'b0, 5'h08, 8'h0);
        chk(v, 32'hC0 | cfg);
        chk(core.conv_reset, 1'b1);
        wr(5'h08, cfg);
        xfer(1'b0, 5'h08, 8'h0);
        chk(v, 32'h40 | cfg);
        for (int i = 0; i < 40 && v[6] !== 1'b0; i++)
            xfer(1'b0, 5'h08, 8'h0);
        chk(v, {24'h0, cfg});
        xfer(1'b0, 5'h04, 8'h0);
        chk(v, res[15:8]);
        xfer(1'b0, 5'h00, 8'h0);
        chk(v, res[7:0]);
    endtask

    task automatic conclude;
        if (n_errors == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Hang guard, well past the expected run length
    initial
    begin
        #(25 * 20000);
        n_errors++;
        conclude();
    end

    initial
    begin
        {rst_b, wb_cyc_i, wb_stb_i, wb_we_i} = 4'b0000;
        {wb_adr_i, wb_dat_i, wb_sel_i} = {5'h0, 32'h0, 4'h1};
        sample = 12'hABC;
        repeat (16) @(posedge clock);
        rst_b <= 1'b1;
        // Reset values and an unmapped place
        xfer(1'b0, 5'h08, 8'h0);
        chk(v, 32'h60);
        xfer(1'b0, 5'h10, 8'h0);
        chk(v, 32'hFF);
        xfer(1'b0, 5'h14, 8'h0);
        chk(v, 32'h0);
        // Pin enables and pull-high removal
        wr(5'h10, 8'h5A);
        v = {16'h0, pin_analog_enable_bits, pull_high_block};
        chk(v, 32'h5A5A);
        // Bandgap routing detaches every pin; bandgap enabled first
        wr(5'h0C, 8'h40);
        wr(5'h0C, 8'hFF);
        xfer(1'b0, 5'h0C, 8'h0);
        chk(v, 32'hD7);
        wr(5'h08, 8'h03);
        v = {core.bandgap_connect, core.bandgap_enable,
             core.reference_source_select, core.channel_connect};
        chk(v, 32'h700);
        wr(5'h0C, 8'h00);
        // Every channel code, bit 3 written high
        for (int c = 0; c < 8; c++)
        begin
            wr(5'h08, 8'h08 | c[7:0]);
            xfer(1'b0, 5'h08, 8'h0);
            chk(v, 32'h40 | c);
            chk(core.channel_connect, 8'h1 << c);
        end
        chk(core.converter_power_down, 1'b0);
        // Start while powered down never converts
        wr(5'h08, 8'hA0);
        wr(5'h08, 8'h20);
        repeat (40) @(posedge clock);
        xfer(1'b0, 5'h08, 8'h0);
        chk(v, 32'h60);
        conv(8'h00, 16'hABC0);
        conv(8'h15, 16'h0ABC);
        // Divider codes, including the undefined one
        for (int d = 0; d < 8; d++)
        begin
            wr(5'h0C, d[7:0]);
            cnt = 0;
            repeat (128) @(posedge clock) cnt += core.conv_clock_en;
            chk(cnt, d == 7 ? 0 : 128 >> d);
        end
        // Power down before a low-power mode
        wr(5'h08, 8'h20);
        chk(core.converter_power_down, 1'b1);
        conclude();
    end
endmodule // tb_top

//--- verilog/adcc_ctrl.sv
// Register-side control of the 12-bit converter: five byte registers,
// start sequencing, busy flag, channel routing and clock divider.
// Assumes the converter core raises conv_done for one cycle with the result.
//
// The Wishbone interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/10ps
module adcc_ctrl
    import adcc_pkg::*;
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst_b,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [4:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Converter core
    input  wire logic        conv_done,
    input  wire logic [11:0] conv_result,
    output adcc_core_s       core,
    // Pin control
    output logic      [7:0]  pin_analog_enable_bits,
    output logic      [7:0]  pull_high_block
);
    // Software registers, then internal state and decode signals
    logic        start_bit;
    logic        busy;
    logic        converter_power_down;
    logic        result_justify_select;
    logic [2:0]  channel_select_field;
    adcc_ctrl1_s ctrl1;
    logic [7:0]  pin_en;
    logic [15:0] result;
    logic [5:0]  div_cnt;
    adcc_state_e state;
    logic        wr_strobe;
    logic        wr_lane0;
    logic [7:0]  rd_byte;
    logic [7:0]  ctrl0_view;
    logic [7:0]  ctrl1_view;
    logic [5:0]  div_mask;

    // Byte lane 0 carries all register data; writes land at the edge
    // where the master samples ack, so an early abort writes nothing
    assign wr_strobe = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
    assign wr_lane0  = wr_strobe && wb_sel_i[0];

    // Bit 3 reads zero; busy forced while start held high
    assign ctrl0_view = {start_bit, busy | start_bit, converter_power_down,
                         result_justify_select, 1'b0,
                         channel_select_field};
    assign ctrl1_view = {ctrl1.bandgap_input_select, ctrl1.bandgap_enable,
                         1'b0, ctrl1.reference_source_select, 1'b0,
                         ctrl1.conv_clock_divider};

    // Read decode; unmapped offsets read zero
    always_comb
    begin
        case (wb_adr_i)
            5'(ADCC_OFF_RES_LOW):  rd_byte = result[7:0];
            5'(ADCC_OFF_RES_HIGH): rd_byte = result[15:8];
            5'(ADCC_OFF_CTRL0):    rd_byte = ctrl0_view;
            5'(ADCC_OFF_CTRL1):    rd_byte = ctrl1_view;
            ADCC_OFF_PINEN:        rd_byte = pin_en;
            default:               rd_byte = 8'h00;
        endcase
    end

    // One wait state: ack a cycle after the request, then drop it
    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else
        begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
            wb_dat_o <= {24'h00_0000, rd_byte};
        end
    end

    // Ack is a one-cycle pulse, so a held request is not answered in two cycles running
    a_ack_single: assert property (
        @(posedge clock) disable iff (!rst_b)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held for two cycles");

    // Primary control writes
    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            start_bit             <= 1'b0;
            converter_power_down  <= 1'b1;
            result_justify_select <= 1'b0;
            channel_select_field  <= 3'h0;
        end
        else if (wr_lane0 && wb_adr_i == 5'(ADCC_OFF_CTRL0))
        begin
            start_bit             <= wb_dat_i[ADCC_C0_START];
            converter_power_down  <= wb_dat_i[ADCC_C0_PDOWN];
            result_justify_select <= wb_dat_i[ADCC_C0_JUSTIFY];
            channel_select_field  <= wb_dat_i[2:0];
        end
    end

    // Reset values show at the first edge after release
    a_reset_state: assert property (
        @(posedge clock) disable iff (!rst_b)
        !$past(rst_b) |-> busy && converter_power_down && !start_bit
            && !result_justify_select && channel_select_field == 3'h0)
        else $error("control register left reset with wrong values");

    // Unimplemented bit 3 and the upper data lanes never read high
    a_bit3_reads_zero: assert property (
        @(posedge clock) disable iff (!rst_b)
        $past(rst_b) && $past(wb_adr_i) == 5'(ADCC_OFF_CTRL0)
            |-> wb_dat_o[3] == 1'b0 && wb_dat_o[31:8] == 24'h00_0000)
        else $error("unimplemented control bit read high");

    // Secondary control and pin enable writes
    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            ctrl1  <= adcc_ctrl1_s'(ADCC_RST_CTRL1);
            pin_en <= ADCC_RST_PINEN;
        end
        else if (wr_lane0)
        begin
            if (wb_adr_i == 5'(ADCC_OFF_CTRL1))
            begin
                ctrl1.bandgap_input_select    <= wb_dat_i[ADCC_C1_BGSEL];
                ctrl1.bandgap_enable          <= wb_dat_i[ADCC_C1_BGEN];
                ctrl1.reference_source_select <= wb_dat_i[ADCC_C1_REFSEL];
                ctrl1.conv_clock_divider      <= wb_dat_i[2:0];
            end
            if (wb_adr_i == ADCC_OFF_PINEN)
                pin_en <= wb_dat_i[7:0];
        end
    end

    // Start sequencer: a rising then falling start bit fires one conversion when powered up
    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            state <= ADCC_IDLE;
            busy  <= 1'b1;
        end
        else if (start_bit)
        begin
            state <= ADCC_ARMED;
            busy  <= 1'b1;
        end
        else
        begin
            case (state)
                ADCC_ARMED:
                begin
                    // Powered off: nothing to run, leave busy raised
                    if (!converter_power_down)
                        state <= ADCC_CONV;
                    else
                        state <= ADCC_IDLE;
                end
                ADCC_CONV:
                begin
                    if (conv_done)
                    begin
                        state <= ADCC_IDLE;
                        busy  <= 1'b0;
                    end
                end
                default: state <= ADCC_IDLE;
            endcase
        end
    end

    // A low start bit never leaves the sequencer armed
    a_armed_exit: assert property (
        @(posedge clock) disable iff (!rst_b)
        (state == ADCC_ARMED && !start_bit) |=> state != ADCC_ARMED)
        else $error("sequencer stuck armed");

    // Idle sequencer never launches the converter
    a_idle_no_start: assert property (
        @(posedge clock) disable iff (!rst_b)
        state == ADCC_IDLE |=> !core.conv_start)
        else $error("conversion started from idle");

    // Start released while powered off: back to idle, busy still set
    a_powered_off_busy: assert property (
        @(posedge clock) disable iff (!rst_b)
        (state == ADCC_ARMED && !start_bit && converter_power_down)
            |=> busy && state == ADCC_IDLE)
        else $error("powered-off start did not return to idle");

    // Busy stays set for the whole of a conversion
    a_busy_holds: assert property (
        @(posedge clock) disable iff (!rst_b)
        state == ADCC_CONV |-> busy)
        else $error("busy low during conversion");

    // Result load in the selected justification
    always_ff @(posedge clock)
    begin
        if (!rst_b)
            result <= 16'h0000;
        else if (state == ADCC_CONV && conv_done && !start_bit)
            result <= adcc_justify(conv_result,
                                   result_justify_select);
    end

    // Left justified: low nibble of the low byte reads zero
    a_justify_left: assert property (
        @(posedge clock) disable iff (!rst_b)
        (state == ADCC_CONV && conv_done && !start_bit
            && !result_justify_select)
            |=> result == {$past(conv_result), 4'h0})
        else $error("left justified result misplaced");

    // Right justified: upper nibble of the high byte reads zero
    a_justify_right: assert property (
        @(posedge clock) disable iff (!rst_b)
        (state == ADCC_CONV && conv_done && !start_bit
            && result_justify_select)
            |=> result == {4'h0, $past(conv_result)})
        else $error("right justified result misplaced");

    // Divider mask: code k divides by 2**k; the undefined code stops it
    always_comb
    begin
        div_mask = 6'((7'h01 << ctrl1.conv_clock_divider) - 7'h01);
    end

    // Free running prescaler for the converter clock enable
    always_ff @(posedge clock)
    begin
        if (!rst_b)
            div_cnt <= 6'h00;
        else
            div_cnt <= div_cnt + 6'h01;
    end

    // Converter core and pin lines, all registered
    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            core                   <= '0;
            pin_analog_enable_bits <= ADCC_RST_PINEN;
            pull_high_block        <= ADCC_RST_PINEN;
        end
        else
        begin
            core.conv_reset  <= start_bit;
            core.conv_start  <= state == ADCC_ARMED && !start_bit
                                && !converter_power_down;
            core.converter_power_down <= converter_power_down;
            core.channel_connect <= ctrl1.bandgap_input_select ? 8'h00
                : 8'(8'h01 << channel_select_field);
            core.bandgap_connect <= ctrl1.bandgap_input_select;
            core.bandgap_enable  <= ctrl1.bandgap_enable;
            core.reference_source_select <= ctrl1.reference_source_select;
            core.conv_clock_en <= ctrl1.conv_clock_divider != ADCC_DIV_UNDEF
                && (div_cnt & div_mask) == 6'h00;
            pin_analog_enable_bits <= pin_en;
            pull_high_block        <= pin_en;
        end
    end

    // Busy reads high whenever start is held
    a_busy_under_start: assert property (
        @(posedge clock) disable iff (!rst_b)
        start_bit |-> ctrl0_view[ADCC_C0_BUSY])
        else $error("busy low while start held");

    // Start bit high then low before the converter is launched
    a_start_needs_fall: assert property (
        @(posedge clock) disable iff (!rst_b)
        core.conv_start |-> $past(start_bit, 2) && !$past(start_bit))
        else $error("conversion began without full start pulse");

    // Conversion end clears busy in the next cycle
    a_done_clears_busy: assert property (
        @(posedge clock) disable iff (!rst_b)
        (state == ADCC_CONV && conv_done && !start_bit) |=> !busy)
        else $error("busy not cleared at conversion end");

    // Bandgap selected: every external channel is open
    a_bandgap_isolates: assert property (
        @(posedge clock) disable iff (!rst_b)
        $past(ctrl1.bandgap_input_select) |-> core.channel_connect == 8'h00)
        else $error("external input connected with bandgap");

    // Pull-high block follows the pin enables one cycle later
    a_pullup_removed: assert property (
        @(posedge clock) disable iff (!rst_b)
        $past(rst_b) |-> pull_high_block == $past(pin_en))
        else $error("pull-high not removed on analog pin");

    // Converter reset line mirrors the start bit
    a_start_resets: assert property (
        @(posedge clock) disable iff (!rst_b)
        $past(rst_b) |-> core.conv_reset == $past(start_bit))
        else $error("converter reset does not follow start");

    // A powered-off converter is never launched
    a_power_blocks: assert property (
        @(posedge clock) disable iff (!rst_b)
        core.conv_start |-> !core.converter_power_down)
        else $error("conversion launched while powered off");

    // Channel field picks exactly the addressed input
    a_channel_route: assert property (
        @(posedge clock) disable iff (!rst_b)
        $past(rst_b) && !$past(ctrl1.bandgap_input_select)
            |-> core.channel_connect
                == 8'(8'h01 << $past(channel_select_field)))
        else $error("wrong analog input connected");

    // Bandgap connection follows its select bit
    a_bandgap_route: assert property (
        @(posedge clock) disable iff (!rst_b)
        $past(rst_b) |-> core.bandgap_connect
            == $past(ctrl1.bandgap_input_select))
        else $error("bandgap connection wrong");

    // Undefined divider code gives no converter clock at all
    a_divider_stopped: assert property (
        @(posedge clock) disable iff (!rst_b)
        $past(ctrl1.conv_clock_divider) == ADCC_DIV_UNDEF
            |-> !core.conv_clock_en)
        else $error("converter clock runs on undefined code");

    // Pin outputs follow the enable register one cycle later
    a_pin_enable_copy: assert property (
        @(posedge clock) disable iff (!rst_b)
        $past(rst_b) |-> pin_analog_enable_bits == $past(pin_en))
        else $error("pin analog enables out of step");
endmodule // adcc_ctrl

//--- verilog/adcc_pkg.sv
// Constants, register map and carriers for the converter control block.
// Assumes a classic Wishbone slave with 32-bit data, byte data in bits 7:0.
package adcc_pkg;
    // Register byte offsets
    localparam logic [3:0] ADCC_OFF_RES_LOW  = 4'h0;
    localparam logic [3:0] ADCC_OFF_RES_HIGH = 4'h4;
    localparam logic [3:0] ADCC_OFF_CTRL0    = 4'h8;
    localparam logic [3:0] ADCC_OFF_CTRL1    = 4'hC;
    localparam logic [4:0] ADCC_OFF_PINEN    = 5'h10;
    // Primary control field positions
    localparam int ADCC_C0_START  = 7;
    localparam int ADCC_C0_BUSY   = 6;
    localparam int ADCC_C0_PDOWN  = 5;
    localparam int ADCC_C0_JUSTIFY = 4;
    // Secondary control field positions
    localparam int ADCC_C1_BGSEL  = 7;
    localparam int ADCC_C1_BGEN   = 6;
    localparam int ADCC_C1_REFSEL = 4;
    // Reset values and the undefined divider code
    localparam logic [7:0] ADCC_RST_CTRL1 = 8'h00;
    localparam logic [7:0] ADCC_RST_PINEN = 8'hFF;
    localparam logic [2:0] ADCC_DIV_UNDEF = 3'h7;

    // Secondary control fields
    typedef struct packed {
        logic       bandgap_input_select;
        logic       bandgap_enable;
        logic       reference_source_select;
        logic [2:0] conv_clock_divider;
    } adcc_ctrl1_s;

    // Lines toward the analog converter core
    typedef struct packed {
        logic       conv_reset;
        logic       conv_start;
        logic       converter_power_down;
        logic [7:0] channel_connect;
        logic       bandgap_connect;
        logic       bandgap_enable;
        logic       reference_source_select;
        logic       conv_clock_en;
    } adcc_core_s;

    typedef enum logic [1:0] {ADCC_IDLE, ADCC_ARMED, ADCC_CONV} adcc_state_e;

    // Justify a 12-bit result into the high and low bytes
    function automatic logic [15:0] adcc_justify(input logic [11:0] r,
                                                 input logic j);
        if (j)
            adcc_justify = {4'h0, r};
        else
            adcc_justify = {r, 4'h0};
    endfunction
endpackage
